// file: src/aei_defines.vh
// Register offsets, bit positions and reset values of the event interrupt block.
// Assumes inclusion by bare name from design files under src/.
`ifndef AEI_DEFINES_VH
`define AEI_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define AEI_STATUS_OFS 4'h0
`define AEI_MASK_OFS 4'h4
`define AEI_CTRL_OFS 4'h8
`define AEI_LEVEL_OFS 4'hC

// ****************************************
// Event bit positions
// ****************************************
`define AEI_BIT_ACQ_RUN 0
`define AEI_BIT_ACQ_STOP 1
`define AEI_BIT_ACQ_DONE 2
`define AEI_BIT_IN_FIFO 3
`define AEI_BIT_CONV 4
`define AEI_BIT_EOSCAN 5
`define AEI_BIT_EOSEQ 6
`define AEI_BIT_WAV_RUN 7
`define AEI_BIT_WAV_DONE 8
`define AEI_BIT_OUT_FIFO 9
`define AEI_BIT_HIGH_CH 10
`define AEI_BIT_RETX 11
`define AEI_BIT_EXT 12
`define AEI_NUM_EVENTS 13

// ****************************************
// Control fields, reset values and FIFO depths
// ****************************************
`define AEI_CTRL_EXT_FALL 0
`define AEI_CTRL_RETX_MODE 1
`define AEI_STATUS_RST 13'h0000
`define AEI_MASK_RST 13'h0000
`define AEI_CTRL_RST 2'h0
`define AEI_FIFO_DEPTH 16'h2000
`define AEI_OUT_FIFO_DEPTH 16'h4000

`endif

// file: src/aei_event_irq.v
// Event interrupt block: sticky event flags, enable mask, level interrupt.
// Assumes event strobes and levels synchronous to clk_i; Wishbone classic slave.
`timescale 1ns/1ps
`include "aei_defines.vh"

module aei_event_irq (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Acquisition sequencer
	input wire acq_running_i,
	input wire acq_stop_trig_i,
	input wire acq_finished_i,
	input wire [15:0] in_fifo_level_i,
	input wire per_conversion_i,
	input wire end_of_scan_i,
	input wire end_of_sequence_i,
	// Waveform sequencer
	input wire wav_running_i,
	input wire wav_finished_i,
	input wire [15:0] out_fifo_level_i,
	input wire high_channel_i,
	input wire retx_wrap_i,
	// External pin
	input wire ext_irq_i,
	// Interrupt to host, active high level
	output reg irq_o
);

	// ****************************************
	// State
	// ****************************************
	// Sticky event flags, write one to clear
	reg [12:0] status_reg;
	// Per-source enables, one means enabled
	reg [12:0] mask_reg;
	// External edge select and retransmit mode
	reg [1:0] ctrl_reg;

	// ****************************************
	// Next values
	// ****************************************
	// Events seen in this cycle
	reg [12:0] event_next;
	// Flags that software asks to clear
	reg [12:0] clear_next;
	// Flags after set and clear
	reg [12:0] status_next;
	// Enables after a mask write
	reg [12:0] mask_next;
	// Control after a control write
	reg [1:0] ctrl_next;
	// Read data for the addressed register
	reg [31:0] rdata_next;
	// Level interrupt before its flop
	reg irq_next;

	// ****************************************
	// Decode and event wires
	// ****************************************
	// Bus request and register selects
	wire acc;
	wire wr;
	wire status_wr;
	wire mask_wr;
	wire ctrl_wr;
	// Threshold levels of both FIFOs
	wire in_quarter;
	wire out_quarter;
	// Threshold crossings
	wire in_quarter_rise;
	wire out_quarter_rise;
	// Pin edges
	wire stop_rise;
	wire ext_rise;
	wire ext_fall;
	// Acquisition sources
	wire acq_running_event;
	wire acq_stop_event;
	wire acq_finished_event;
	wire in_fifo_quarter_event;
	wire per_conversion_event;
	wire end_of_scan_event;
	wire end_of_sequence_event;
	// Waveform sources
	wire wav_running_event;
	wire wav_finished_event;
	wire out_fifo_quarter_event;
	wire high_channel_event;
	wire retx_wrap_event;
	// External pin source
	wire ext_event;

	// ****************************************
	// Bus decode
	// ****************************************
	// One answer per request; held strobe waits for ack to fall
	assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = acc & wb_we_i;
	// Register selects for writes
	assign status_wr = wr & (wb_adr_i == `AEI_STATUS_OFS);
	assign mask_wr = wr & (wb_adr_i == `AEI_MASK_OFS);
	assign ctrl_wr = wr & (wb_adr_i == `AEI_CTRL_OFS);

	// ****************************************
	// Threshold and pin edge detection
	// ****************************************
	// Quarter thresholds of both FIFOs
	assign in_quarter = in_fifo_level_i >= (`AEI_FIFO_DEPTH >> 2);
	assign out_quarter = out_fifo_level_i <= (`AEI_OUT_FIFO_DEPTH >> 2);

	// Input FIFO reaching a quarter full
	aei_edge_det aei_edge_det_in_i (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.level_i(in_quarter),
		.rise_o(in_quarter_rise),
		.fall_o()
	);

	// Output FIFO draining to a quarter
	aei_edge_det aei_edge_det_out_i (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.level_i(out_quarter),
		.rise_o(out_quarter_rise),
		.fall_o()
	);

	// Stop trigger input, rising edge only
	aei_edge_det aei_edge_det_stop_i (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.level_i(acq_stop_trig_i),
		.rise_o(stop_rise),
		.fall_o()
	);

	// External interrupt pin, both edges
	aei_edge_det aei_edge_det_ext_i (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.level_i(ext_irq_i),
		.rise_o(ext_rise),
		.fall_o(ext_fall)
	);

	// ****************************************
	// Event sources
	// ****************************************
	// Acquisition sequencer
	assign acq_running_event = acq_running_i;
	assign acq_stop_event = stop_rise;
	assign acq_finished_event = acq_finished_i;
	assign in_fifo_quarter_event = in_quarter_rise;
	assign per_conversion_event = per_conversion_i;
	assign end_of_scan_event = end_of_scan_i;
	assign end_of_sequence_event = end_of_sequence_i;

	// Waveform sequencer
	assign wav_running_event = wav_running_i;
	assign wav_finished_event = wav_finished_i;
	assign out_fifo_quarter_event = out_quarter_rise;
	assign high_channel_event = high_channel_i;
	// Wraps count only in retransmit mode
	assign retx_wrap_event = retx_wrap_i & ctrl_reg[`AEI_CTRL_RETX_MODE];

	// Selected edge of external pin
	assign ext_event = ctrl_reg[`AEI_CTRL_EXT_FALL] ? ext_fall : ext_rise;

	// ****************************************
	// Event collection
	// ****************************************
	// Gather sources into flag positions
	always @* begin
		event_next = 13'h0000;
		event_next[`AEI_BIT_ACQ_RUN] = acq_running_event;
		event_next[`AEI_BIT_ACQ_STOP] = acq_stop_event;
		event_next[`AEI_BIT_ACQ_DONE] = acq_finished_event;
		event_next[`AEI_BIT_IN_FIFO] = in_fifo_quarter_event;
		event_next[`AEI_BIT_CONV] = per_conversion_event;
		event_next[`AEI_BIT_EOSCAN] = end_of_scan_event;
		event_next[`AEI_BIT_EOSEQ] = end_of_sequence_event;
		event_next[`AEI_BIT_WAV_RUN] = wav_running_event;
		event_next[`AEI_BIT_WAV_DONE] = wav_finished_event;
		event_next[`AEI_BIT_OUT_FIFO] = out_fifo_quarter_event;
		event_next[`AEI_BIT_HIGH_CH] = high_channel_event;
		event_next[`AEI_BIT_RETX] = retx_wrap_event;
		event_next[`AEI_BIT_EXT] = ext_event;
	end

	// ****************************************
	// Flag clear and update
	// ****************************************
	// Write one to clear, byte lanes honoured
	always @* begin
		clear_next = 13'h0000;
		if (status_wr && wb_sel_i[0]) begin
			clear_next[7:0] = wb_dat_i[7:0];
		end
		if (status_wr && wb_sel_i[1]) begin
			clear_next[12:8] = wb_dat_i[12:8];
		end
	end

	// Set beats clear in the same cycle
	always @* begin
		status_next = (status_reg & ~clear_next) | event_next;
	end

	// ****************************************
	// Enable and control update
	// ****************************************
	// Per-source enable, byte lanes honoured
	always @* begin
		mask_next = mask_reg;
		if (mask_wr && wb_sel_i[0]) begin
			mask_next[7:0] = wb_dat_i[7:0];
		end
		if (mask_wr && wb_sel_i[1]) begin
			mask_next[12:8] = wb_dat_i[12:8];
		end
	end

	// Edge select and retransmit mode from lane 0
	always @* begin
		ctrl_next = ctrl_reg;
		if (ctrl_wr && wb_sel_i[0]) begin
			ctrl_next = wb_dat_i[1:0];
		end
	end

	// Level interrupt from enabled pending flags
	always @* begin
		irq_next = |(status_next & mask_reg);
	end

	// Read data mux
	always @* begin
		rdata_next = 32'h00000000;
		case (wb_adr_i)
			`AEI_STATUS_OFS: rdata_next = {19'h00000, status_reg};
			`AEI_MASK_OFS: rdata_next = {19'h00000, mask_reg};
			`AEI_CTRL_OFS: rdata_next = {30'h00000000, ctrl_reg};
			`AEI_LEVEL_OFS: rdata_next = {in_fifo_level_i, out_fifo_level_i};
			default: rdata_next = 32'h00000000;
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	// Sticky event flags
	always @(posedge clk_i) begin
		if (rst_i) begin
			status_reg <= `AEI_STATUS_RST;
		end else begin
			status_reg <= status_next;
		end
	end

	// Source enables
	always @(posedge clk_i) begin
		if (rst_i) begin
			mask_reg <= `AEI_MASK_RST;
		end else begin
			mask_reg <= mask_next;
		end
	end

	// Control bits
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= `AEI_CTRL_RST;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// Bus answer one cycle after the request is taken
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= acc;
			wb_dat_o <= acc ? rdata_next : 32'h00000000;
		end
	end

	// Interrupt line to host
	always @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= irq_next;
		end
	end

endmodule // aei_event_irq

// ****************************************
// Edge detector
// ****************************************
// One-cycle strobes on each change of a level; the delay flop
// resets low, so a pin idling low gives no false edge after reset.
module aei_edge_det (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Sampled level
	input wire level_i,
	// One-cycle edge strobes
	output wire rise_o,
	output wire fall_o
);

	// Level seen at the previous edge
	reg level_d_reg;

	// Edges against the delayed copy
	assign rise_o = level_i & ~level_d_reg;
	assign fall_o = ~level_i & level_d_reg;

	// Delay flop
	always @(posedge clk_i) begin
		if (rst_i) begin
			level_d_reg <= 1'b0;
		end else begin
			level_d_reg <= level_i;
		end
	end

endmodule // aei_edge_det

// file: testbench/aei_event_irq_monitor.sv
// Bus and interrupt relations at the block ports.
// Assumes binding onto aei_event_irq.
`timescale 1ns/1ps
module aei_event_irq_monitor (
	input wire clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o,
	input wire [3:0] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire [15:0] in_fifo_level_i, out_fifo_level_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
	a_req_gets_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack");
	a_idle_no_ack: assert property (!wb_cyc_i |=> !wb_ack_o) else $error("stray ack");
	a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 0) else $error("dat");
	a_level_read: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == 4'hC)
		|-> wb_dat_o == {$past(in_fifo_level_i), $past(out_fifo_level_i)}) else $error("lvl");
	a_odd_read_zero: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i[1:0] != 0)
		|-> wb_dat_o == 0) else $error("odd");
	a_irq_held: assert property (irq_o && !(wb_cyc_i && wb_we_i) |=> irq_o)
		else $error("irq drop");
	a_irq_fall_cause: assert property ($fell(irq_o) |-> $past(wb_cyc_i && wb_we_i))
		else $error("irq fell");
endmodule // aei_event_irq_monitor
bind aei_event_irq aei_event_irq_monitor aei_event_irq_monitor_i (.*);

// file: testbench/aei_host_model.sv
// Host model: classic Wishbone single cycles.
// Assumes the block answers on the shared clock.
`timescale 1ns/1ps
module aei_host_model (
	input wire clk_i, ack_i,
	input wire [31:0] dat_i,
	output reg cyc_o = 0, stb_o = 0, we_o = 0,
	output reg [3:0] adr_o = 0, sel_o = 0,
	output reg [31:0] dat_o = 0
);
	// Hold request until ack sampled, then release
	task xfer(input w, input [3:0] a, input [31:0] d, output [31:0] q);
		int k;
		bit got;
		got = 0;
		@(posedge clk_i);
		{cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'hF, d};
		for (k = 0; k < 20 && !got; k++) begin
			@(posedge clk_i);
			got = ack_i;
			q = dat_i;
		end
		{cyc_o, stb_o} <= 2'b00;
		if (!got) test_acquisition_event_interrupts.test_done(1);
	endtask
endmodule // aei_host_model

// file: testbench/test_acquisition_event_interrupts.sv
// Self-checking run of the event interrupt block.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
module test_acquisition_event_interrupts;
	logic clk_i = 0, rst_i = 1, cyc, stb, we, ack, irq;
	logic [3:0] adr, sel;
	logic [31:0] wd, rd, q;
	logic [12:0] ev = 0;
	logic [15:0] lin = 16'h07FF, lout = 16'h1001;
	int err_total = 0, n_compared = 0, i;
	initial forever #2.5 clk_i = ~clk_i;
	aei_host_model aei_host_model_i (.clk_i(clk_i), .ack_i(ack), .dat_i(rd), .cyc_o(cyc),
		.stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
	aei_event_irq aei_event_irq_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd),
		.wb_ack_o(ack), .acq_running_i(ev[0]), .acq_stop_trig_i(ev[1]),
		.acq_finished_i(ev[2]), .in_fifo_level_i(lin), .per_conversion_i(ev[4]),
		.end_of_scan_i(ev[5]), .end_of_sequence_i(ev[6]), .wav_running_i(ev[7]),
		.wav_finished_i(ev[8]), .out_fifo_level_i(lout), .high_channel_i(ev[10]),
		.retx_wrap_i(ev[11]), .ext_irq_i(ev[12]), .irq_o(irq));
	task chk(input string s, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task rdc(input string s, input [3:0] a, input [31:0] e);
		aei_host_model_i.xfer(0, a, 0, q);
		chk(s, e, q);
	endtask
	task test_done(input int hung);
		err_total += hung;
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 0;
		rdc("status", 4'h0, 0);
		aei_host_model_i.xfer(1, 4'h4, 32'h1FFF, q);
		aei_host_model_i.xfer(1, 4'h8, 2, q);
		// Each source alone, boundary fifo levels
		for (i = 0; i < 13; i++) begin
			@(posedge clk_i);
			ev <= 13'h1 << i;
			if (i == 3) lin <= 16'h0800;
			if (i == 9) lout <= 16'h1000;
			@(posedge clk_i);
			{ev, lin, lout} <= {13'h0, 16'h07FF, 16'h1001};
			rdc("event", 4'h0, 32'h1 << i);
			chk("irq", 1, irq);
			aei_host_model_i.xfer(1, 4'h0, 32'h1 << i, q);
			chk("irq", 0, irq);
		end
		// Masked, retransmit off, falling edge
		aei_host_model_i.xfer(1, 4'h4, 0, q);
		aei_host_model_i.xfer(1, 4'h8, 1, q);
		@(posedge clk_i) ev <= 13'h1810;
		@(posedge clk_i) ev <= 13'h1000;
		rdc("masked", 4'h0, 32'h10);
		chk("irq", 0, irq);
		@(posedge clk_i) ev <= 0;
		rdc("fall", 4'h0, 32'h1010);
		rdc("level", 4'hC, 32'h07FF1001);
		rdc("unmapped", 4'h2, 0);
		rdc("mask", 4'h4, 0);
		rdc("ctrl", 4'h8, 1);
		// Running level re-sets its flag over a clear
		@(posedge clk_i) ev <= 13'h1;
		aei_host_model_i.xfer(1, 4'h0, 32'h1FFF, q);
		rdc("set wins", 4'h0, 1);
		aei_host_model_i.xfer(1, 4'h4, 1, q);
		@(posedge clk_i) ev <= 0;
		chk("irq", 1, irq);
		test_done(0);
	end
endmodule // test_acquisition_event_interrupts
